// ==== common/cscm_pkg.sv ====
package cscm_pkg;
	// 16-bit control word carried on the serial port
	typedef struct packed {
		logic cd;
		logic rw;
		logic [2:0] dev_addr;
		logic [2:0] reg_addr;
		logic [7:0] data;
	} cscm_word_t;

	localparam int WORD_BITS = 16;
	localparam logic [3:0] WORD_LAST = 4'hf;
	localparam int UNITS = 2;
	localparam int REGS = 8;

	// register indices within one unit
	localparam logic [2:0] REG_SERIAL_MODE = 3'h0;
	localparam logic [2:0] REG_CLOCK_RATE = 3'h1;
	localparam logic [2:0] REG_POWER = 3'h2;
	localparam logic [2:0] REG_GAIN = 3'h3;
	localparam logic [2:0] REG_DAC_TIMING = 3'h4;
	localparam logic [2:0] REG_ANALOG_TAP = 3'h5;
	localparam logic [2:0] REG_DTAP_LOW = 3'h6;
	localparam logic [2:0] REG_DTAP_HIGH = 3'h7;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;

	// serial_mode_control fields
	localparam int OPERATING_MODE_SELECT = 0;
	localparam int MIXED_MODE_ENABLE = 1;
	localparam int CASCADE_COUNT_LSB = 4;
	localparam int SOFT_RESET_BIT = 7;
	// clock_and_rate_config fields
	localparam int SAMPLE_RATE_LSB = 0;
	localparam int SERIAL_CLOCK_DIVIDER_LSB = 2;
	localparam int CONTROL_ECHO_ENABLE = 7;
	// power_control fields
	localparam int GLOBAL_POWER_UP = 0;
	localparam int SECTION_POWER_LSB = 1;
	localparam int REFERENCE_POWER = 5;
	localparam int REFERENCE_OUTPUT_ENABLE = 6;
	localparam int HIGH_SUPPLY_MODE_ENABLE = 7;
	// dac_timing_and_tap_enable writable bits
	localparam logic [7:0] DAC_TIMING_MASK = 8'h7f;

	// timing in internal master clock cycles
	localparam int SOFT_RESET_CYCLES = 4;
	localparam logic [2:0] SOFT_RESET_LOAD = 3'h4;
	localparam logic [11:0] SLOW_RATE_LAST = 12'h7ff;
	localparam logic [11:0] BOOT_FSYNC_CYCLES = 12'h7ff;
	localparam logic [3:0] SCLK_SLOW_DIV = 4'h8;
endpackage

// ==== src/cscm_serial_ctrl.sv ====
`timescale 1ns/1ps
// Overview of operation
// (RULE1) every transfer is a 16-bit packet
// (RULE2) mode bit0 data, bit1 mixed mode
// (RULE3) bits 4-6 hold cascade count
// (RULE4) soft reset bit, four cycles, clears all
// (RULE5) program mode; first fsync after 2048
// (RULE6) fsync rate INTERNAL_MASTER_CLOCK/2048 until rate programmed
// (RULE7) program mode output carries no data
// (RULE8) config writes only program or mixed mode
// (RULE9) address zero selects this device
// (RULE10) nonzero address decremented and forwarded
// (RULE11) two addresses, zero and one, standalone
// (RULE12) host aligns control words with output words
// (RULE13) data mode counts fsyncs, loads DAC
// (RULE14) normal data mode ignores control words
// (RULE15) global power-up overrides section power bits
// (RULE16) reference bits ORed across both units
// (RULE17) bit6 reference out, bit7 5V mode
// (RULE18) gain register field layout
// (RULE19) dac timing layout, bit7 reserved zero
// (RULE20) analog tap register field layout
// (RULE21) digital tap coefficient split low/high
// (RULE22) clock and rate register field layout
// (RULE23) control word field layout
// (RULE24) read copies register into data field
// (RULE25) rate codes 2048/1024/512/256
// (RULE26) serial clock codes 8/4/2/1
// (RULE27) forwarded word leaves in arrival slot
// (RULE28) soft reset bit clears itself
module cscm_serial_ctrl
	import cscm_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_port_enable_pin,
	input wire logic i_sdi,
	input wire logic i_input_frame_sync,
	input wire logic [15:0] i_adc_word,
	output logic o_sclk,
	output logic o_sdo,
	output logic o_output_frame_sync,
	output logic [15:0] o_dac_word0,
	output logic [15:0] o_dac_word1,
	output logic [127:0] o_regs,
	output logic [1:0] o_unit_power,
	output logic [9:0] o_section_power,
	output logic o_reference_power,
	output logic o_reference_output_enable,
	output logic o_high_supply_mode_enable
);
	typedef logic [7:0] cscm_bank_t [UNITS][REGS];

	// rate field to last count of the sample period
	function automatic logic [11:0] cscm_period_last(input logic [1:0] code);
		cscm_period_last = (SLOW_RATE_LAST >> code); // RULE25 RULE6
	endfunction

	// serial clock field to divide ratio
	function automatic logic [3:0] cscm_sclk_div(input logic [1:0] code);
		cscm_sclk_div = (SCLK_SLOW_DIV >> code); // RULE26
	endfunction

	cscm_bank_t regs;
	logic [2:0] sync_se, sync_sdi, sync_ifs;
	logic se_f, sdi_f, ifs_f;
	logic [2:0] srst_cnt;
	logic [3:0] div_cnt;
	logic [11:0] samp_cnt;
	logic sample_due;
	logic tx_busy;
	logic [3:0] tx_cnt;
	logic [15:0] tx_sr;
	logic rx_busy;
	logic [3:0] rx_cnt;
	logic [15:0] rx_sr;
	logic word_done;
	logic [15:0] rx_word;
	logic [2:0] ifs_idx;
	logic fwd_pending;
	logic [15:0] fwd_word;

	// three-stage pin synchronisers, change accepted when stages two and three agree
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_se <= 3'h0;
			sync_sdi <= 3'h0;
			sync_ifs <= 3'h0;
		end else begin
			sync_se <= {sync_se[1:0], i_port_enable_pin};
			sync_sdi <= {sync_sdi[1:0], i_sdi};
			sync_ifs <= {sync_ifs[1:0], i_input_frame_sync};
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			se_f <= 1'b0;
			sdi_f <= 1'b0;
			ifs_f <= 1'b0;
		end else begin
			se_f <= (sync_se[1] == sync_se[2]) ? sync_se[2] : se_f;
			sdi_f <= (sync_sdi[1] == sync_sdi[2]) ? sync_sdi[2] : sdi_f;
			ifs_f <= (sync_ifs[1] == sync_ifs[2]) ? sync_ifs[2] : ifs_f;
		end
	end

	// mode decode from unit 0 only, unit 1 mode and rate registers are not decoded
	wire [7:0] mode_reg = regs[0][REG_SERIAL_MODE];
	wire [7:0] rate_reg = regs[0][REG_CLOCK_RATE];
	wire data_mode = mode_reg[OPERATING_MODE_SELECT]; // RULE2
	wire mixed_mode = mode_reg[MIXED_MODE_ENABLE]; // RULE2
	wire normal_data = data_mode & ~mixed_mode; // RULE14
	wire cfg_writable = ~data_mode | mixed_mode; // RULE8
	wire [2:0] casc_count = mode_reg[CASCADE_COUNT_LSB +: 3]; // RULE3
	wire echo_en = rate_reg[CONTROL_ECHO_ENABLE]; // RULE22
	wire [11:0] period_last = cscm_period_last(rate_reg[SAMPLE_RATE_LSB +: 2]);
	wire [3:0] sclk_div = cscm_sclk_div(rate_reg[SERIAL_CLOCK_DIVIDER_LSB +: 2]);
	wire srst_active = (srst_cnt != 3'h0);

	// serial clock divider, tick marks one serial bit
	wire sclk_tick = se_f & (div_cnt == sclk_div - 4'h1);
	wire [3:0] next_div_cnt = sclk_tick ? 4'h0 : (div_cnt + 4'h1);
	wire next_sclk = (sclk_div == 4'h1) | (next_div_cnt < (sclk_div >> 1));

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div_cnt <= 4'h0;
			o_sclk <= 1'b1;
		end else begin
			div_cnt <= se_f ? next_div_cnt : 4'h0;
			o_sclk <= next_sclk;
		end
	end

	// sample period counter, first period 2048 cycles from reset release
	wire samp_wrap = (samp_cnt >= period_last); // RULE5 RULE6
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			samp_cnt <= 12'h0;
		end else begin
			samp_cnt <= samp_wrap ? 12'h0 : samp_cnt + 12'h1;
		end
	end

	// decoding of a received word
	cscm_word_t cw;
	assign cw = rx_word; // RULE23
	wire is_ctrl = ~normal_data & (~data_mode | cw.cd); // RULE14
	wire is_dac = normal_data | (mixed_mode & ~cw.cd); // RULE13
	wire ctrl_ok = word_done & is_ctrl & cfg_writable; // RULE8
	wire for_unit0 = (cw.dev_addr == 3'h0); // RULE9
	wire for_unit1 = (cw.dev_addr == 3'h1); // RULE11
	wire own_word = for_unit0 | for_unit1;
	wire sel_unit = for_unit1;
	wire do_write = ctrl_ok & own_word & ~cw.rw;
	wire do_read = ctrl_ok & own_word & cw.rw;
	wire do_fwd = ctrl_ok & ~own_word; // RULE10
	wire [7:0] rd_data = regs[sel_unit][cw.reg_addr];

	// word sent on: decremented past both units, read data or echo
	cscm_word_t fwd_next;
	always_comb begin
		fwd_next = cw;
		if (do_fwd) begin
			fwd_next.dev_addr = cw.dev_addr - 3'h2; // RULE10 RULE11
		end else if (do_read) begin
			fwd_next.data = rd_data; // RULE24
		end
	end
	wire fwd_set = do_fwd | do_read | (do_write & echo_en); // RULE24 RULE22
	wire dac0_hit = word_done & is_dac & (ifs_idx == casc_count); // RULE13
	wire dac1_hit = word_done & is_dac & (ifs_idx == casc_count + 3'h1); // RULE13

	// value written, reserved timing bit forced to zero
	wire [7:0] wr_val = (cw.reg_addr == REG_DAC_TIMING) ? (cw.data & DAC_TIMING_MASK) : cw.data; // RULE19
	wire srst_req = do_write & (cw.reg_addr == REG_SERIAL_MODE) & cw.data[SOFT_RESET_BIT]; // RULE4

	// control register bank with software reset
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			regs <= '{default: REG_RESET_VAL};
			srst_cnt <= 3'h0;
		end else if (srst_active) begin
			regs <= '{default: REG_RESET_VAL}; // RULE4 RULE28
			srst_cnt <= srst_cnt - 3'h1;
		end else begin
			if (do_write) begin
				regs[sel_unit][cw.reg_addr] <= wr_val; // RULE9 RULE18 RULE20 RULE21
			end
			srst_cnt <= srst_req ? SOFT_RESET_LOAD : 3'h0; // RULE4
		end
	end

	// input framing: sync seen on a tick, then sixteen data bits
	wire rx_start = sclk_tick & ~rx_busy & ifs_f;
	wire rx_shift = sclk_tick & rx_busy;
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_busy <= 1'b0;
			rx_cnt <= 4'h0;
			rx_sr <= 16'h0;
			word_done <= 1'b0;
			rx_word <= 16'h0;
		end else begin
			word_done <= rx_shift & (rx_cnt == WORD_LAST); // RULE1
			if (rx_start) begin
				rx_busy <= 1'b1;
				rx_cnt <= 4'h0;
			end else if (rx_shift) begin
				rx_sr <= {rx_sr[14:0], sdi_f};
				rx_cnt <= rx_cnt + 4'h1;
				if (rx_cnt == WORD_LAST) begin
					rx_busy <= 1'b0;
					rx_word <= {rx_sr[14:0], sdi_f};
				end
			end
		end
	end

	// output framing: forwarded word has priority, then the sample frame
	wire tx_load = sclk_tick & ~tx_busy & (fwd_pending | sample_due);
	wire load_fwd = tx_load & fwd_pending; // RULE27
	wire [15:0] samp_word = (data_mode ? i_adc_word : 16'h0); // RULE7
	wire [15:0] tx_next_word = load_fwd ? fwd_word : samp_word;
	wire next_fwd_pending = fwd_set | (fwd_pending & ~load_fwd);
	wire next_sample_due = samp_wrap | (sample_due & ~(tx_load & ~fwd_pending));

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sample_due <= 1'b0;
			fwd_pending <= 1'b0;
			fwd_word <= 16'h0;
			tx_busy <= 1'b0;
			tx_cnt <= 4'h0;
			tx_sr <= 16'h0;
			o_sdo <= 1'b0;
			o_output_frame_sync <= 1'b0;
		end else begin
			sample_due <= next_sample_due;
			fwd_pending <= next_fwd_pending; // set wins over clear
			if (fwd_set) begin
				fwd_word <= fwd_next;
			end
			if (tx_load) begin
				tx_busy <= 1'b1;
				tx_cnt <= 4'h0;
				tx_sr <= {tx_next_word[14:0], 1'b0};
				o_sdo <= tx_next_word[15];
				o_output_frame_sync <= 1'b1;
			end else if (sclk_tick & tx_busy) begin
				o_output_frame_sync <= 1'b0;
				tx_cnt <= tx_cnt + 4'h1;
				tx_sr <= {tx_sr[14:0], 1'b0};
				o_sdo <= tx_sr[15];
				tx_busy <= (tx_cnt != WORD_LAST);
			end
		end
	end

	// input frame index since the last sample frame, and DAC registers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ifs_idx <= 3'h0;
			o_dac_word0 <= 16'h0;
			o_dac_word1 <= 16'h0;
		end else begin
			if (tx_load & ~fwd_pending) begin
				ifs_idx <= 3'h0;
			end else if (word_done & is_dac) begin
				ifs_idx <= ifs_idx + 3'h1; // RULE13
			end
			if (dac0_hit) begin
				o_dac_word0 <= rx_word;
			end
			if (dac1_hit) begin
				o_dac_word1 <= rx_word;
			end
		end
	end

	// power decode, reference bits shared by both units
	wire [7:0] pw0 = regs[0][REG_POWER];
	wire [7:0] pw1 = regs[1][REG_POWER];
	wire [7:0] pw_or = pw0 | pw1; // RULE16
	wire [4:0] sec0 = pw0[SECTION_POWER_LSB +: 5] | {5{pw0[GLOBAL_POWER_UP]}}; // RULE15
	wire [4:0] sec1 = pw1[SECTION_POWER_LSB +: 5] | {5{pw1[GLOBAL_POWER_UP]}}; // RULE15

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_regs <= 128'h0;
			o_unit_power <= 2'h0;
			o_section_power <= 10'h0;
			o_reference_power <= 1'b0;
			o_reference_output_enable <= 1'b0;
			o_high_supply_mode_enable <= 1'b0;
		end else begin
			o_regs <= {regs[1][7], regs[1][6], regs[1][5], regs[1][4], regs[1][3], regs[1][2], regs[1][1],
				regs[1][0], regs[0][7], regs[0][6], regs[0][5], regs[0][4], regs[0][3], regs[0][2],
				regs[0][1], regs[0][0]};
			o_unit_power <= {pw1[GLOBAL_POWER_UP] | (|sec1), pw0[GLOBAL_POWER_UP] | (|sec0)};
			o_section_power <= {sec1, sec0};
			o_reference_power <= pw_or[REFERENCE_POWER] | pw0[GLOBAL_POWER_UP] | pw1[GLOBAL_POWER_UP]; // RULE16
			o_reference_output_enable <= pw_or[REFERENCE_OUTPUT_ENABLE]; // RULE17
			o_high_supply_mode_enable <= pw_or[HIGH_SUPPLY_MODE_ENABLE]; // RULE17
		end
	end

	// helper: cycles since reset release, saturating
	logic [11:0] boot_cnt;
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			boot_cnt <= 12'h0;
		end else if (boot_cnt != 12'hfff) begin
			boot_cnt <= boot_cnt + 12'h1;
		end
	end

	a_soft_reset_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE4
		$rose(srst_active) |-> srst_active[*4] ##1 !srst_active)
		else $error("soft reset not four cycles");
	a_soft_reset_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE28
		(srst_cnt == 3'h1) |=> (regs[0][REG_SERIAL_MODE] == 8'h00) && (regs[1][REG_POWER] == 8'h00))
		else $error("soft reset left registers set");
	a_first_fsync: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE5
		$rose(o_output_frame_sync) |-> (boot_cnt > BOOT_FSYNC_CYCLES))
		else $error("frame sync before 2048 cycles");
	a_data_ignore: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE14
		(word_done && normal_data && !srst_active) |=> $stable(regs[0][REG_SERIAL_MODE]) && !$rose(fwd_pending))
		else $error("control word acted on in data mode");
	a_addr_zero_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE9
		(do_write && !srst_active && !srst_req && for_unit0) |=> (regs[0][$past(cw.reg_addr)] == $past(wr_val)))
		else $error("addressed write not stored");
	a_forward_dec: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE10
		do_fwd |=> fwd_pending && (fwd_word[13:11] == $past(cw.dev_addr) - 3'h2))
		else $error("forwarded address not decremented");
	a_ref_or: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE16
		##1 (o_reference_output_enable == $past(pw0[REFERENCE_OUTPUT_ENABLE] | pw1[REFERENCE_OUTPUT_ENABLE])))
		else $error("reference enable not ORed");
	a_dac_select: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE13
		dac0_hit |=> (o_dac_word0 == $past(rx_word)))
		else $error("DAC word not loaded on matching frame");
	a_prog_out_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE7
		(tx_load && !fwd_pending && !data_mode) |=> (o_sdo == 1'b0) && o_output_frame_sync)
		else $error("program mode sample frame not blank");
endmodule

// ==== tb/cscm_host_model.sv ====
`timescale 1ns/1ps
// dsp serial port model: sends framed words and captures every output word
module cscm_host_model
	import cscm_pkg::*;
#(
	parameter int DIV = 8
)
(
	input wire logic i_core_clk,
	input wire logic i_sclk,
	input wire logic i_sdo,
	input wire logic i_ofs,
	output logic o_sdi,
	output logic o_ifs
);
	logic [15:0] rx = 16'h0000;
	logic [15:0] sh = 16'h0000;
	int rx_cnt = 0;

	initial begin
		o_sdi = 1'b0;
		o_ifs = 1'b0;
	end

	// one sync tick, then sixteen bits msb first, each held a whole sclk period
	task automatic send(input logic [15:0] w);
		@(posedge i_sclk);
		@(negedge i_core_clk);
		o_ifs = 1'b1;
		for (int i = 15; i >= 0; i--) begin
			@(posedge i_sclk);
			@(negedge i_core_clk);
			o_ifs = 1'b0;
			o_sdi = w[i];
		end
		@(posedge i_sclk);
		@(negedge i_core_clk);
		o_sdi = ~o_sdi; // released line must not show a stale bit
	endtask

	// samples each output bit mid-period, starting at the sync bit
	initial begin
		forever begin
			@(posedge i_ofs);
			repeat (DIV / 2) @(posedge i_core_clk);
			for (int i = 0; i < 16; i++) begin
				sh = {sh[14:0], i_sdo};
				if (i < 15) repeat (DIV) @(posedge i_core_clk);
			end
			rx = sh;
			rx_cnt++;
		end
	end
endmodule

// ==== tb/codec_serial_control_and_mode_logic_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, (ex), (got)); end end
module codec_serial_control_and_mode_logic_tb import cscm_pkg::*;;
	logic i_core_clk, i_rst_b, i_port_enable_pin, i_sdi, i_input_frame_sync;
	logic [15:0] i_adc_word, o_dac_word0, o_dac_word1;
	logic o_sclk, o_sdo, o_output_frame_sync, o_reference_power;
	logic o_reference_output_enable, o_high_supply_mode_enable;
	logic [127:0] o_regs;
	logic [1:0] o_unit_power;
	logic [9:0] o_section_power;
	logic [7:0] exp_regs [16];
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;

	cscm_serial_ctrl dut_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_port_enable_pin(i_port_enable_pin),
		.i_sdi(i_sdi), .i_input_frame_sync(i_input_frame_sync), .i_adc_word(i_adc_word), .o_sclk(o_sclk),
		.o_sdo(o_sdo), .o_output_frame_sync(o_output_frame_sync), .o_dac_word0(o_dac_word0),
		.o_dac_word1(o_dac_word1), .o_regs(o_regs), .o_unit_power(o_unit_power),
		.o_section_power(o_section_power), .o_reference_power(o_reference_power),
		.o_reference_output_enable(o_reference_output_enable),
		.o_high_supply_mode_enable(o_high_supply_mode_enable));
	cscm_host_model #(.DIV(8)) host_u (.i_core_clk(i_core_clk), .i_sclk(o_sclk), .i_sdo(o_sdo),
		.i_ofs(o_output_frame_sync), .o_sdi(i_sdi), .o_ifs(i_input_frame_sync));

	// 20 mhz core clock
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end

	function automatic logic [15:0] cw(logic rw, logic [2:0] a, logic [2:0] r, logic [7:0] d);
		cscm_word_t w;
		w = '{cd: 1'b1, rw: rw, dev_addr: a, reg_addr: r, data: d};
		return w;
	endfunction

	// control write, then time for the bank and its copy to settle
	task automatic wr(input logic [2:0] a, input logic [2:0] r, input logic [7:0] d);
		host_u.send(cw(1'b0, a, r, d));
		repeat (24) @(negedge i_core_clk);
	endtask

	task automatic chk_regs();
		for (int k = 0; k < 16; k++) `CHK("register byte", exp_regs[k], o_regs[k*8 +: 8])
	endtask

	task automatic clr_regs();
		for (int k = 0; k < 16; k++) exp_regs[k] = 8'h00;
	endtask

	// cycles up to the next rising edge of sclk (sel) or output sync
	task automatic gap(input bit sel, output int n);
		n = 0;
		while ((sel ? o_sclk : o_output_frame_sync) !== 1'b0 && n < 5000) begin
			@(negedge i_core_clk);
			n++;
		end
		while ((sel ? o_sclk : o_output_frame_sync) !== 1'b1 && n < 5000) begin
			@(negedge i_core_clk);
			n++;
		end
	endtask

	// waits for a captured output word that carries control
	task automatic wait_rx(output logic [15:0] w);
		int c0;
		int t;
		c0 = host_u.rx_cnt;
		for (t = 0; t < 6000; t++) begin
			@(negedge i_core_clk);
			if (host_u.rx_cnt != c0) begin
				c0 = host_u.rx_cnt;
				if (host_u.rx[15] === 1'b1) break;
			end
		end
		w = host_u.rx;
	endtask

	task automatic done_t(input string s);
		$display("test %s finished", s);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// hang guard, well above the expected run length
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			results();
		end
	end

	initial begin
		int n;
		logic [7:0] d;
		logic [15:0] w;
		i_rst_b = 1'b0;
		i_port_enable_pin = 1'b1;
		i_adc_word = 16'h5a3c;
		clr_regs();
		repeat (8) @(negedge i_core_clk);
		`CHK("sclk in reset", 1'b1, o_sclk)
		chk_regs();
		i_rst_b = 1'b1;
		gap(1'b0, n);
		`CHK("first sync window", 1'b1, (n >= 2048 && n <= 2064))
		gap(1'b0, n);
		`CHK("default sync period", 2048, n)
		`CHK("program mode output", 16'h0000, host_u.rx)
		`CHK("program frames seen", 1'b1, (host_u.rx_cnt > 0))
		done_t("reset");
		for (int u = 0; u < 2; u++) for (int r = 3; r < 8; r++) begin
			d = {1'b1, u[0], r[2:0], 3'h5};
			wr(u[2:0], r[2:0], d);
			exp_regs[u*8+r] = (r == 4) ? (d & DAC_TIMING_MASK) : d;
		end
		chk_regs();
		wr(3'h0, REG_POWER, 8'h60);
		wr(3'h1, REG_POWER, 8'h81);
		exp_regs[2] = 8'h60;
		exp_regs[10] = 8'h81;
		`CHK("unit power", 2'b11, o_unit_power)
		`CHK("section power", {5'h1f, 5'h10}, o_section_power)
		`CHK("reference power", 1'b1, o_reference_power)
		`CHK("reference output", 1'b1, o_reference_output_enable)
		`CHK("high supply", 1'b1, o_high_supply_mode_enable)
		done_t("registers");
		host_u.send(cw(1'b1, 3'h0, REG_GAIN, 8'h00));
		wait_rx(w);
		`CHK("read reply", cw(1'b1, 3'h0, REG_GAIN, exp_regs[3]), w)
		host_u.send(cw(1'b0, 3'h3, REG_GAIN, 8'h77));
		wait_rx(w);
		`CHK("forwarded word", cw(1'b0, 3'h1, REG_GAIN, 8'h77), w)
		chk_regs();
		done_t("addressing");
		wr(3'h0, REG_CLOCK_RATE, 8'h71);
		wr(3'h1, REG_CLOCK_RATE, 8'h71);
		exp_regs[1] = 8'h71;
		exp_regs[9] = 8'h71;
		chk_regs();
		gap(1'b0, n);
		gap(1'b0, n);
		gap(1'b0, n);
		`CHK("programmed sync period", 1024, n)
		wr(3'h1, REG_SERIAL_MODE, 8'h80);
		clr_regs();
		chk_regs();
		`CHK("power after soft reset", 2'b00, o_unit_power)
		done_t("rate and soft reset");
		wr(3'h0, REG_SERIAL_MODE, 8'h11);
		exp_regs[0] = 8'h11;
		gap(1'b0, n);
		repeat (150) @(negedge i_core_clk);
		host_u.send(16'h1111);
		host_u.send(16'h2222);
		host_u.send(16'h3333);
		host_u.send(cw(1'b0, 3'h0, REG_GAIN, 8'hee));
		repeat (24) @(negedge i_core_clk);
		`CHK("dac word 0", 16'h2222, o_dac_word0)
		`CHK("dac word 1", 16'h3333, o_dac_word1)
		chk_regs();
		gap(1'b0, n);
		repeat (150) @(negedge i_core_clk);
		`CHK("data mode output", 16'h5a3c, host_u.rx)
		done_t("data mode");
		i_rst_b = 1'b0;
		repeat (8) @(negedge i_core_clk);
		i_rst_b = 1'b1;
		clr_regs();
		chk_regs();
		gap(1'b1, n);
		gap(1'b1, n);
		`CHK("default sclk period", 8, n)
		// mixed mode: cd low words are converter data, control still accepted
		wr(3'h0, REG_SERIAL_MODE, 8'h13);
		exp_regs[0] = 8'h13;
		gap(1'b0, n);
		repeat (150) @(negedge i_core_clk);
		host_u.send(16'h0123);
		host_u.send(16'h0456);
		wr(3'h0, REG_GAIN, 8'h42);
		exp_regs[3] = 8'h42;
		`CHK("mixed dac word 0", 16'h0456, o_dac_word0)
		chk_regs();
		done_t("mixed mode");
		wr(3'h0, REG_CLOCK_RATE, 8'h04);
		gap(1'b1, n);
		gap(1'b1, n);
		gap(1'b1, n);
		`CHK("faster sclk period", 4, n)
		done_t("hardware reset and sclk");
		results();
	end
endmodule
